// ===== hw/fsc_pkg.sv
// Constants, register map and field layout for the frequency sweep control block
// How it works
// [RULE_01] New step or rate taken mid-sweep
// [RULE_02] Ramped FSK bounded; chirp has no top
// [RULE_03] Clear bit write zeroes frequency accumulator once
// [RULE_04] Held clear bit re-clears on each update
// [RULE_05] Clearing leaves the step word intact
// [RULE_06] Dual clear holds both accumulators at zero
// [RULE_07] Words written during dual clear apply after
// [RULE_08] Host loads start, step, rate, then updates
// [RULE_09] Settings reach core only on update; the code applies the control byte and update period at once
// [RULE_10] Step sign picks sweep direction
// [RULE_11] Chirp never returns to start by itself
// [RULE_12] Freeze pin halts chirp ramp counter
// [RULE_13] Ramp counter finishes old count before reload
// [RULE_14] Update counter runs on system clock; the code steps it on every second cycle
// [RULE_15] Zero step keeps frequency still
// [RULE_16] Host may sawtooth via update clock clears
// [RULE_17] Ramp pulse every programmed value plus one
// [RULE_18] Each ramp pulse adds step to accumulator; the code subtracts it in ramped FSK going down
// [RULE_19] Ramped FSK runs until destination reached
// [RULE_20] Freeze pin synchronised before gating
package fsc_pkg;
  // Port and word widths
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 8;
  localparam int FTW_W     = 48;
  localparam int RATE_W    = 20;
  localparam int UPD_W     = 32;
  localparam int MEM_DEPTH = 32;
  // Byte offsets, most significant byte at the lowest address
  localparam logic [5:0] ADDR_START = 6'h04;
  localparam logic [5:0] ADDR_HIGH  = 6'h0a;
  localparam logic [5:0] ADDR_STEP  = 6'h10;
  localparam logic [5:0] ADDR_UPD   = 6'h16;
  localparam logic [5:0] ADDR_RATE  = 6'h1a;
  localparam logic [5:0] ADDR_CTRL  = 6'h1f;
  // Control byte fields
  localparam int CTRL_CLR1_BIT    = 0;
  localparam int CTRL_CLR2_BIT    = 1;
  localparam int CTRL_INT_UPD_BIT = 2;
  localparam int CTRL_MODE_LSB    = 4;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Operating modes
  localparam logic [2:0] MODE_SINGLE  = 3'h0;
  localparam logic [2:0] MODE_UNRAMP  = 3'h1;
  localparam logic [2:0] MODE_RAMPED  = 3'h2;
  localparam logic [2:0] MODE_CHIRP   = 3'h3;
  // Timing
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int UPD_HIGH_CYCLES   = 8;
  localparam logic [3:0] UPD_HIGH_CNT = 4'(UPD_HIGH_CYCLES);
endpackage : fsc_pkg

// ===== hw/fsc_ramp_counter.sv
// Ramp rate countdown counter producing sweep step pulses
`timescale 1ns/1ps
`default_nettype none
module fsc_ramp_counter
  import fsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              run,
  input  wire logic              hold,
  input  wire logic              restart,
  input  wire logic [RATE_W-1:0] rate,
  output logic                   tick,
  output logic [RATE_W-1:0]      count
);
  logic [RATE_W-1:0] cnt_reg;  // Present count

  // Countdown; apart from restart, reload happens only at zero, so a new rate waits out the old count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= rate;  // Restart keeps the previous rate
    end else if (run && !hold) begin  // RULE_12
      if (cnt_reg == '0) begin
        cnt_reg <= rate;  // RULE_13
      end else begin
        cnt_reg <= cnt_reg - 1'b1;  // RULE_17
      end
    end
  end

  // Pulse at zero: spacing is rate plus one cycles
  assign tick  = run && !hold && (cnt_reg == '0);  // RULE_17
  assign count = cnt_reg;
endmodule : fsc_ramp_counter
`default_nettype wire

// ===== hw/fsc_update_clock.sv
// Update strobe: external edge synchroniser and internal periodic generator
`timescale 1ns/1ps
`default_nettype none
module fsc_update_clock
  import fsc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             int_mode,
  input  wire logic [UPD_W-1:0] period,
  input  wire logic             pin_in,
  output logic                  pin_out,
  output logic                  pin_oe,
  output logic                  upd_evt
);
  logic             s1_reg, s2_reg, s3_reg;  // Pin synchroniser and edge history
  logic             half_reg;                // Half-rate enable
  logic [UPD_W-1:0] cnt_reg;                 // Internal countdown
  logic [3:0]       hi_reg;                  // Output high-time counter
  logic             int_zero;                // Internal count expiry

  // Two-flop synchroniser, edge taken from the second and third stages only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign int_zero = half_reg && (cnt_reg == '0);

  // Internal counter ticks every second system clock, locked to it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      half_reg <= 1'b0;
      cnt_reg  <= '0;
    end else begin
      half_reg <= ~half_reg;  // RULE_14
      if (half_reg) begin
        cnt_reg <= int_zero ? period : cnt_reg - 1'b1;
      end
    end
  end

  // Fixed high time on the pin when generated internally
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hi_reg  <= '0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_oe <= int_mode;
      if (int_mode && int_zero) begin
        hi_reg <= UPD_HIGH_CNT;
      end else if (hi_reg != '0) begin
        hi_reg <= hi_reg - 1'b1;
      end
      pin_out <= int_mode && ((hi_reg != '0) || int_zero);
    end
  end

  // One-cycle transfer event from the selected source
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      upd_evt <= 1'b0;
    end else begin
      upd_evt <= int_mode ? int_zero : (s2_reg && !s3_reg);  // RULE_14
    end
  end
endmodule : fsc_update_clock
`default_nettype wire

// ===== hw/fsc_sweep_control.sv
// Frequency sweep control: register buffer, active core, accumulators
`timescale 1ns/1ps
`default_nettype none
module fsc_sweep_control
  import fsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] par_addr,
  input  wire logic              par_wr,
  input  wire logic              par_rd,
  input  wire logic [DATA_W-1:0] par_wdata,
  output logic [DATA_W-1:0]      par_rdata,
  input  wire logic              keying_select_pin,
  input  wire logic              update_pin_in,
  output logic                   update_pin_out,
  output logic                   update_pin_oe,
  output logic [FTW_W-1:0]       tuning_word,
  output logic [FTW_W-1:0]       phase_word
);
  // Buffered program bytes, host side
  logic [DATA_W-1:0] buf_mem [0:MEM_DEPTH-1];
  // Active core copies, loaded on update only
  logic [FTW_W-1:0]  f1_act_reg;
  logic [FTW_W-1:0]  f2_act_reg;
  logic [FTW_W-1:0]  step_act_reg;
  logic [RATE_W-1:0] rate_act_reg;
  // Accumulators
  logic [FTW_W-1:0]  freq_acc_reg;   // frequency_accumulator
  logic [FTW_W-1:0]  phase_acc_reg;  // phase_accumulator
  // Keying pin synchroniser
  logic              key_s1_reg;
  logic              key_s2_reg;
  // Decoded control and helpers
  logic [7:0]        ctrl;
  logic [2:0]        mode;
  logic              is_chirp;
  logic              is_ramped;
  logic              dual_clr;
  logic              wr_ctrl;
  logic              clr1_now;
  logic              upd_evt;
  logic              hold;
  logic              run;
  logic              tick;
  logic [RATE_W-1:0] ramp_cnt;
  logic [FTW_W-1:0]  span;
  logic [FTW_W:0]    up_sum;
  logic [FTW_W-1:0]  freq_acc_next;
  logic [FTW_W-1:0]  tuning_next;

  // Gather six buffered bytes into a word, first byte most significant
  function automatic logic [FTW_W-1:0] get_word48(input logic [5:0] base);
    logic [FTW_W-1:0] w;
    w = '0;
    for (int i = 0; i < 6; i++) begin
      w = {w[FTW_W-9:0], buf_mem[5'(base + 6'(i))]};
    end
    return w;
  endfunction : get_word48

  // Gather the three ramp rate bytes, upper four bits of first byte unused
  function automatic logic [RATE_W-1:0] get_rate(input logic [5:0] base);
    return {buf_mem[5'(base)][3:0], buf_mem[5'(base + 6'h01)], buf_mem[5'(base + 6'h02)]};
  endfunction : get_rate

  // Control decode
  assign ctrl      = buf_mem[5'(ADDR_CTRL)];
  assign mode      = ctrl[CTRL_MODE_LSB +: 3];
  assign is_chirp  = (mode == MODE_CHIRP);
  assign is_ramped = (mode == MODE_RAMPED);
  assign dual_clr  = ctrl[CTRL_CLR2_BIT];
  assign wr_ctrl   = par_wr && (par_addr == ADDR_CTRL);

  // One-cycle clear on each write with the bit set, and on every update while held
  assign clr1_now = (wr_ctrl && par_wdata[CTRL_CLR1_BIT])  // RULE_03
                 || (upd_evt && ctrl[CTRL_CLR1_BIT]);     // RULE_04

  // Host byte writes; the buffer is free to change at any time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        buf_mem[i] <= (i == int'(ADDR_CTRL)) ? CTRL_RST : BYTE_RST;
      end
    end else if (par_wr && !par_addr[5]) begin
      buf_mem[par_addr[4:0]] <= par_wdata;  // RULE_07
    end
  end

  // Reads see the buffer, never the active core
  // Read port: buffered values, zero above the map
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      par_rdata <= '0;
    end else if (par_rd) begin
      par_rdata <= par_addr[5] ? '0 : buf_mem[par_addr[4:0]];
    end
  end

  // Transfer buffer to core on update; also lets the slope change mid-ramp
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      f1_act_reg   <= '0;
      f2_act_reg   <= '0;
      step_act_reg <= '0;
      rate_act_reg <= '0;
    end else if (upd_evt) begin  // RULE_09
      f1_act_reg   <= get_word48(ADDR_START);
      f2_act_reg   <= get_word48(ADDR_HIGH);
      step_act_reg <= get_word48(ADDR_STEP);  // RULE_01
      rate_act_reg <= get_rate(ADDR_RATE);    // RULE_01
    end
  end

  // Keying and freeze pin synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
    end else begin
      key_s1_reg <= keying_select_pin;  // RULE_20
      key_s2_reg <= key_s1_reg;         // RULE_20
    end
  end

  // Freeze only in chirp mode, and only from the synchronised level
  assign hold = is_chirp && key_s2_reg;  // RULE_12
  assign span = f2_act_reg - f1_act_reg;

  // Run conditions: chirp free-runs, ramped FSK stops at its destination
  // A parked counter keeps its partial count for the next run
  always_comb begin
    run = 1'b0;
    if (!dual_clr) begin
      if (is_chirp) begin
        run = 1'b1;  // RULE_11
      end else if (is_ramped) begin
        run = key_s2_reg ? (freq_acc_reg != span) : (freq_acc_reg != '0);  // RULE_19
      end
    end
  end

  // Ramp rate counter
  fsc_ramp_counter u_ramp (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .run     (run),
    .hold    (hold),
    .restart (clr1_now),
    .rate    (rate_act_reg),
    .tick    (tick),
    .count   (ramp_cnt)
  );

  // Update strobe source
  fsc_update_clock u_upd (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .int_mode (ctrl[CTRL_INT_UPD_BIT]),
    .period   ({buf_mem[5'(ADDR_UPD)], buf_mem[5'(ADDR_UPD + 6'h01)],
                buf_mem[5'(ADDR_UPD + 6'h02)], buf_mem[5'(ADDR_UPD + 6'h03)]}),
    .pin_in   (update_pin_in),
    .pin_out  (update_pin_out),
    .pin_oe   (update_pin_oe),
    .upd_evt  (upd_evt)
  );

  // Next accumulator value on a ramp pulse
  // Carry kept so an upward wrap can still be clamped
  assign up_sum = {1'b0, freq_acc_reg} + {1'b0, step_act_reg};
  always_comb begin
    freq_acc_next = freq_acc_reg;
    if (is_chirp) begin
      freq_acc_next = up_sum[FTW_W-1:0];  // RULE_10
    end else if (key_s2_reg) begin
      // Clamp at the high tuning frequency, even on wrap
      freq_acc_next = (up_sum[FTW_W] || (up_sum[FTW_W-1:0] >= span)) ? span : up_sum[FTW_W-1:0];  // RULE_02
    end else begin
      // Ramp down toward the low tuning frequency
      freq_acc_next = (freq_acc_reg <= step_act_reg) ? '0 : freq_acc_reg - step_act_reg;  // RULE_02
    end
  end

  // Frequency accumulator; clears never touch the step word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      freq_acc_reg <= '0;
    end else if (dual_clr) begin
      freq_acc_reg <= '0;  // RULE_06
    end else if (clr1_now) begin
      freq_acc_reg <= '0;  // RULE_03 RULE_05
    end else if (tick) begin
      freq_acc_reg <= freq_acc_next;  // RULE_18 RULE_15
    end
  end

  // Tuning word selection per mode
  always_comb begin
    tuning_next = f1_act_reg;
    unique case (mode)
      MODE_SINGLE: tuning_next = f1_act_reg;
      MODE_UNRAMP: tuning_next = key_s2_reg ? f2_act_reg : f1_act_reg;
      MODE_RAMPED: tuning_next = f1_act_reg + freq_acc_reg;  // RULE_18
      MODE_CHIRP:  tuning_next = f1_act_reg + freq_acc_reg;  // RULE_11
      default:     tuning_next = f1_act_reg;  // Unused mode codes fall back to single tone
    endcase
  end

  // One register stage between sweep sum and phase step
  // Registered tuning word; forced to 0 Hz under dual clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tuning_word <= '0;
    end else begin
      tuning_word <= dual_clr ? '0 : tuning_next;  // RULE_06
    end
  end

  // Phase accumulator
  // Wraps freely; only dual clear stops it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_acc_reg <= '0;
    end else if (dual_clr) begin
      phase_acc_reg <= '0;  // RULE_06
    end else begin
      phase_acc_reg <= phase_acc_reg + tuning_word;
    end
  end
  assign phase_word = phase_acc_reg;

  // Checks
  // All on the system clock, asleep through reset
  // Clear checks leave out dual clear, which has priority
  // Sweep checks skip cycles with a clear, since the clear
  // wins over a ramp pulse in the same cycle
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_clr_write;
    wr_ctrl && par_wdata[CTRL_CLR1_BIT] && !dual_clr;
  endsequence
  sequence s_acc_zero;
    freq_acc_reg == '0;
  endsequence

  // Active step follows the buffer at each update
  property p_step_take;
    upd_evt |=> step_act_reg == $past(get_word48(ADDR_STEP));
  endproperty
  a_step_take: assert property (p_step_take) else $error("step word not taken on update"); // RULE_01

  // Ramped sweep stays inside its span
  property p_fsk_range;
    is_ramped && $past(is_ramped) && $stable(span) && $past(freq_acc_reg <= span) && !$past(upd_evt)
      |-> freq_acc_reg <= span;
  endproperty
  a_fsk_range: assert property (p_fsk_range) else $error("ramped sweep left its range"); // RULE_02

  // Clear bit write zeroes the accumulator next cycle
  property p_clr1_write;
    s_clr_write |=> s_acc_zero;
  endproperty
  a_clr1_write: assert property (p_clr1_write) else $error("clear write missed"); // RULE_03

  // Held clear bit restarts on update at the old rate
  property p_clr1_retrig;
    upd_evt && ctrl[CTRL_CLR1_BIT] && !dual_clr && !wr_ctrl
      |=> s_acc_zero ##0 (ramp_cnt == $past(rate_act_reg));
  endproperty
  a_clr1_retrig: assert property (p_clr1_retrig) else $error("update did not re-clear"); // RULE_04

  // A clear alone never touches the step word
  property p_step_keep;
    clr1_now && !upd_evt |=> $stable(step_act_reg);
  endproperty
  a_step_keep: assert property (p_step_keep) else $error("clear changed step word"); // RULE_05

  // Dual clear pins both accumulators and the tuning word at zero
  property p_dual_hold;
    dual_clr ##1 dual_clr |-> s_acc_zero and (phase_acc_reg == '0 && tuning_word == '0);
  endproperty
  a_dual_hold: assert property (p_dual_hold) else $error("dual clear not held"); // RULE_06

  // Start word and rate copies move only on update
  property p_core_hold;
    !upd_evt |=> $stable(f1_act_reg) && $stable(rate_act_reg);
  endproperty
  a_core_hold: assert property (p_core_hold) else $error("core changed without update"); // RULE_09

  // Chirp pulse adds the signed step
  property p_chirp_add;
    is_chirp && tick && !clr1_now && !dual_clr |=> freq_acc_reg == $past(freq_acc_reg) + $past(step_act_reg);
  endproperty
  a_chirp_add: assert property (p_chirp_add) else $error("chirp step not signed add"); // RULE_10

  // Freeze stops both counter and accumulator
  property p_freeze;
    hold && !clr1_now |=> $stable(freq_acc_reg) && $stable(ramp_cnt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze did not halt sweep"); // RULE_12

  // Running counter steps down by one
  property p_count_down;
    run && !hold && !clr1_now && ramp_cnt != '0 |=> ramp_cnt == $past(ramp_cnt) - 1'b1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("ramp counter reloaded early"); // RULE_13

  // Zero step holds the frequency
  property p_zero_step;
    step_act_reg == '0 && !clr1_now && !dual_clr && is_chirp |=> $stable(freq_acc_reg);
  endproperty
  a_zero_step: assert property (p_zero_step) else $error("zero step moved accumulator"); // RULE_15

  // Pulse reloads the active rate
  property p_reload;
    tick && !clr1_now |=> ramp_cnt == $past(rate_act_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("ramp counter reload wrong"); // RULE_17

  // Ramped sweep parks once the high tuning frequency is reached
  property p_fsk_stop;
    is_ramped && key_s2_reg && freq_acc_reg == span && !clr1_now && !dual_clr |=> $stable(freq_acc_reg);
  endproperty
  a_fsk_stop: assert property (p_fsk_stop) else $error("ramped sweep passed its destination"); // RULE_19

  // Downward ramp never climbs
  property p_ramp_down;
    is_ramped && !key_s2_reg && tick && !clr1_now |=> freq_acc_reg <= $past(freq_acc_reg);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("downward ramp climbed"); // RULE_02

  // Keying level reaches the core two cycles late
  property p_key_sync;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> key_s2_reg == $past(keying_select_pin, 2);
  endproperty
  a_key_sync: assert property (p_key_sync) else $error("keying level not synchronised"); // RULE_20

  // Byte writes land in the buffer, dual clear or not
  property p_buf_write;
    par_wr && !par_addr[5] |=> buf_mem[$past(par_addr[4:0])] == $past(par_wdata);
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("buffer write lost"); // RULE_07
endmodule : fsc_sweep_control
`default_nettype wire

// ===== test/fsc_host_model.sv
// Host controller model: byte-wide register access and keying pin driving
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model
  import fsc_pkg::*;
(
  input  wire logic              ref_clk,
  output logic [ADDR_W-1:0]      par_addr,
  output logic                   par_wr,
  output logic                   par_rd,
  output logic [DATA_W-1:0]      par_wdata,
  input  wire logic [DATA_W-1:0] par_rdata,
  output logic                   key_drv,
  output logic                   upd_drv
);
  // Quiet bus from time zero
  initial begin
    par_addr  = 6'h00;
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    par_wdata = 8'h00;
    key_drv   = 1'b0;
    upd_drv   = 1'b0;
  end
  // One byte write, taken at the edge after setup
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    par_addr  = a;
    par_wdata = d;
    par_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    par_wr    = 1'b0;
    par_wdata = ~d;  // Stale data flipped so it is never mistaken for valid
  endtask : wr
  // Word write, most significant byte at the base address
  task automatic wr_word(input logic [5:0] a, input logic [47:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      wr(a + 6'(i), v[8*(nb-1-i) +: 8]);
    end
  endtask : wr_word
  // One byte read; data is registered at the taking edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    par_addr = a;
    par_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    par_rd   = 1'b0;
    d        = par_rdata;
  endtask : rd
  // Chirp set-up: start word, then step, then rate
  task automatic load_chirp(input logic [47:0] s, input logic [47:0] st, input logic [19:0] r);
    wr_word(ADDR_START, s, 6);
    wr_word(ADDR_STEP, st, 6);
    wr_word(ADDR_RATE, {28'h0, r}, 3);
  endtask : load_chirp
  // External update edge, held long enough for the synchroniser
  task automatic pulse_update;
    @(posedge ref_clk);
    #1;
    upd_drv = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    upd_drv = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : pulse_update
  // Keying level, also the chirp freeze
  task automatic set_key(input logic l);
    @(posedge ref_clk);
    #1;
    key_drv = l;
  endtask : set_key
endmodule : fsc_host_model
`default_nettype wire

// ===== test/fsc_sweep_control_test.sv
// Self-checking bench for the frequency sweep control block
`timescale 1ns/1ps
`default_nettype none
module fsc_sweep_control_test;
  import fsc_pkg::*;
  localparam logic [47:0] START = 48'h0000_1000_0000;
  localparam logic [47:0] HIGH  = 48'h0000_1000_0800;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] par_addr;
  logic              par_wr;
  logic              par_rd;
  logic [DATA_W-1:0] par_wdata;
  logic [DATA_W-1:0] par_rdata;
  logic              key_drv;
  logic              upd_drv;
  logic              upd_wire;
  logic              update_pin_out;
  logic              update_pin_oe;
  logic [FTW_W-1:0]  tuning_word;
  logic [FTW_W-1:0]  phase_word;
  int                n_errors = 0;
  int                comparisons = 0;
  int                n;
  logic [47:0]       t0;
  logic [7:0]        rb;
  // Two-way update pin: design drives it while enabled
  assign upd_wire = update_pin_oe ? update_pin_out : upd_drv;
  always #2 ref_clk = ~ref_clk;
  fsc_host_model fsc_host_model_i (.ref_clk(ref_clk), .par_addr(par_addr), .par_wr(par_wr),
    .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .key_drv(key_drv), .upd_drv(upd_drv));
  fsc_sweep_control fsc_sweep_control_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .par_addr(par_addr),
    .par_wr(par_wr), .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .keying_select_pin(key_drv), .update_pin_in(upd_wire), .update_pin_out(update_pin_out),
    .update_pin_oe(update_pin_oe), .tuning_word(tuning_word), .phase_word(phase_word));
  // Single comparison point
  task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Wait whole cycles, landing just after the edge
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : cyc
  // Frequency change over a window; whole ramp periods give an exact count
  task automatic slope(input string name, input int c, input logic [47:0] exp);
    t0 = tuning_word;
    cyc(c);
    check(name, tuning_word - t0, exp);
  endtask : slope
  // Verdict and end of run
  task automatic end_sim;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Watchdog, far beyond the roughly 1500 cycles the tests need
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    cyc(1);
    check("oe after reset", 48'(update_pin_oe), 48'h1);
    check("tuning after reset", tuning_word, 48'h0);
    fsc_host_model_i.wr(ADDR_CTRL, 8'h30);  // Chirp, external update
    fsc_host_model_i.rd(ADDR_CTRL, rb);
    check("ctrl readback", 48'(rb), 48'h30);
    fsc_host_model_i.wr(6'h20, 8'hff);
    fsc_host_model_i.rd(6'h20, rb);
    check("unmapped read", 48'(rb), 48'h0);
    fsc_host_model_i.load_chirp(START, 48'h100, 20'd9);
    cyc(10);
    check("no update yet", tuning_word, 48'h0);
    fsc_host_model_i.pulse_update();
    cyc(12);
    slope("up slope", 100, 48'ha00);
    slope("free run", 100, 48'ha00);
    // Piecewise slope change mid-sweep
    fsc_host_model_i.wr_word(ADDR_STEP, 48'h300, 6);
    fsc_host_model_i.wr_word(ADDR_RATE, 48'd4, 3);
    fsc_host_model_i.pulse_update();
    cyc(16);
    slope("new slope", 50, 48'h1e00);
    fsc_host_model_i.wr_word(ADDR_STEP, 48'hffff_ffff_fe00, 6);
    fsc_host_model_i.pulse_update();
    cyc(6);
    slope("down slope", 50, 48'hffff_ffff_ec00);
    fsc_host_model_i.wr_word(ADDR_STEP, 48'h0, 6);
    fsc_host_model_i.pulse_update();
    cyc(6);
    slope("zero step", 50, 48'h0);
    // Freeze halts, release resumes
    fsc_host_model_i.wr_word(ADDR_STEP, 48'h100, 6);
    fsc_host_model_i.pulse_update();
    fsc_host_model_i.set_key(1'b1);
    cyc(4);
    slope("frozen", 50, 48'h0);
    fsc_host_model_i.set_key(1'b0);
    cyc(6);
    slope("thawed", 50, 48'ha00);
    // Frequency clear with a slow ramp so no pulse hides the restart
    fsc_host_model_i.wr_word(ADDR_RATE, 48'd60, 3);
    fsc_host_model_i.pulse_update();
    cyc(70);
    fsc_host_model_i.wr(ADDR_CTRL, 8'h31);
    cyc(3);
    check("cleared", tuning_word, START);
    slope("step kept", 61, 48'h100);
    fsc_host_model_i.rd(ADDR_STEP + 6'h4, rb);
    check("step readback", 48'(rb), 48'h01);
    cyc(200);
    fsc_host_model_i.pulse_update();
    cyc(1);
    check("reclear on update", tuning_word, START);
    // Dual clear, reprogrammed while held
    fsc_host_model_i.wr(ADDR_CTRL, 8'h32);
    cyc(3);
    check("dual tuning", tuning_word, 48'h0);
    cyc(20);
    check("dual phase", phase_word, 48'h0);
    fsc_host_model_i.wr_word(ADDR_START, HIGH, 6);
    fsc_host_model_i.wr_word(ADDR_STEP, 48'h0, 6);
    fsc_host_model_i.pulse_update();
    check("dual held", tuning_word, 48'h0);
    fsc_host_model_i.wr(ADDR_CTRL, 8'h30);
    cyc(3);
    check("new start", tuning_word, HIGH);
    check("phase runs", {47'h0, phase_word !== 48'h0}, 48'h1);
    // Ramped FSK between the two tuning words
    fsc_host_model_i.wr(ADDR_CTRL, 8'h21);
    fsc_host_model_i.wr(ADDR_CTRL, 8'h20);
    fsc_host_model_i.wr_word(ADDR_START, START, 6);
    fsc_host_model_i.wr_word(ADDR_HIGH, HIGH, 6);
    fsc_host_model_i.wr_word(ADDR_STEP, 48'h100, 6);
    fsc_host_model_i.wr_word(ADDR_RATE, 48'd3, 3);
    fsc_host_model_i.pulse_update();
    check("fsk low", tuning_word, START);
    fsc_host_model_i.set_key(1'b1);
    cyc(100);
    check("fsk high", tuning_word, HIGH);
    cyc(40);
    check("fsk stopped", tuning_word, HIGH);
    fsc_host_model_i.set_key(1'b0);
    cyc(100);
    check("fsk back", tuning_word, START);
    // Internal update clock, period programmed ahead of the switch
    fsc_host_model_i.wr_word(6'h16, 48'd5, 4);
    fsc_host_model_i.pulse_update();
    fsc_host_model_i.wr(ADDR_CTRL, 8'h34);
    n = 0;
    while (update_pin_out !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (update_pin_out === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    while (update_pin_out === 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    check("update spacing", 48'(n), 48'd12);
    check("pin driven", 48'(update_pin_oe), 48'h1);
    // Sawtooth: held clear bit restarts the chirp on every internal update
    fsc_host_model_i.wr(ADDR_CTRL, 8'h35);
    n = 0;
    while (update_pin_out === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    while (update_pin_out !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(2);
    check("sawtooth restart", tuning_word, START);
    check("sawtooth wait", 48'(n < 200), 48'h1);
    end_sim();
  end
endmodule : fsc_sweep_control_test
`default_nettype wire
